/* File: rtl/rscl_consts.vh */
/*
 holds the constants of the reset strap configuration latch: strap bit
 positions, defaults, register offsets and timing figures.
 assumes inclusion by bare name from design files under rtl/.
*/
`ifndef RSCL_CONSTS_VH
`define RSCL_CONSTS_VH

// ----------------------------------------------------------------------
// strap bit positions within the sampled byte (pin 8 is bit 0)
// ----------------------------------------------------------------------
`define RSCL_SB_NV_HI      7
`define RSCL_SB_NV_LO      6
`define RSCL_SB_SERIAL     5
`define RSCL_SB_STROBE     4
`define RSCL_SB_HALT       3
`define RSCL_SB_WIDE       2
`define RSCL_SB_MAP_RAM    1
`define RSCL_SB_ROM_OFF    0

// ----------------------------------------------------------------------
// strap reset defaults (pins 15..8)
// ----------------------------------------------------------------------
`define RSCL_STRAP_DEFAULT 8'h11

// ----------------------------------------------------------------------
// avalon register offsets (byte addresses, word aligned)
// ----------------------------------------------------------------------
`define RSCL_ADDR_W        4
`define RSCL_OFS_CFG_OPT   4'h0
`define RSCL_OFS_STRAPS    4'h4
`define RSCL_OFS_DECODE    4'h8
`define RSCL_OFS_BOOT      4'hC

// config option register field
`define RSCL_COR_SRST      7

// ----------------------------------------------------------------------
// function register io offsets and window sizes
// ----------------------------------------------------------------------
`define RSCL_IO_COR        8'h40
`define RSCL_IO_CSR        8'h42
`define RSCL_IO_PRR        8'h44
`define RSCL_IO_WIN_SMALL  8'h40
`define RSCL_IO_WIN_LARGE  8'h80

// ----------------------------------------------------------------------
// boot modes
// ----------------------------------------------------------------------
`define RSCL_BOOT_LARGE    2'h0
`define RSCL_BOOT_SMALL    2'h1
`define RSCL_BOOT_NONE     2'h2

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define RSCL_CLK_HZ        100000000
`define RSCL_SER_HZ        400000
`define RSCL_SER_DIV       (`RSCL_CLK_HZ / `RSCL_SER_HZ)
`define RSCL_HOLD_NS       10000
`define RSCL_HOLD_CYC      ((`RSCL_HOLD_NS + 9) / 10)

`endif

/* File: rtl/rscl_sync3.v */
/*
 holds a three flip-flop pin synchroniser with agreement filter.
 assumes a single clock and asynchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none

module rscl_sync3 #(
  parameter W    = 8,
  parameter INIT = 8'h00
) (
  // clock and reset
  input  wire         core_clk,
  input  wire         rstn,
  // pin side
  input  wire [W-1:0] pin_in,
  // core side
  output reg  [W-1:0] pin_out
);

  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  reg [W-1:0] s3_reg;

  // ----------------------------------------------------------------------
  // synchroniser, a change counts once stages two and three agree
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          s1_reg[i]  <= INIT[i];
          s2_reg[i]  <= INIT[i];
          s3_reg[i]  <= INIT[i];
          pin_out[i] <= INIT[i];
        end else begin
          s1_reg[i] <= pin_in[i];
          s2_reg[i] <= s1_reg[i];
          s3_reg[i] <= s2_reg[i];
          if (s2_reg[i] == s3_reg[i]) begin
            pin_out[i] <= s3_reg[i];
          end
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

/* File: rtl/rscl_top.v */
/*
 holds the reset strap configuration latch: samples the strap pins
 during hardware or soft reset, holds them afterwards, and decodes the
 start-up configuration; software reaches it over avalon-mm.
 assumes one 100 MHz clock, the hardware reset pin already asserted
 long enough by the host, and strap levels set by resistors or a host.
*/
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
`include "rscl_consts.vh"

module rscl_top #(
  parameter SER_DIV = `RSCL_SER_DIV
) (
  // clock and reset
  input  wire        core_clk,
  input  wire        rstn,
  // strap pins and hardware reset pin
  input  wire [7:0]  strap_data_pins,
  input  wire [1:0]  legacy_io_pins,
  input  wire        hw_reset_pin,
  // avalon-mm slave
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // decoded configuration and boot serial port rate enable
  output reg         device_in_reset,
  output reg         start_halted,
  output reg         firmware_run_en,
  output reg  [2:0]  nv_device_type,
  output reg  [1:0]  nv_kind_select,
  output reg         serial_host_select,
  output reg         parallel_host_select,
  output reg         pccard_funcs_en,
  output reg         sram_strobe_style,
  output reg         startup_width_wide,
  output reg         store_map_to_ram,
  output reg         onchip_rom_off,
  output reg         legacy_bus_select,
  output reg         attr_space_en,
  output reg         function_regs_io_decode,
  output reg         host_addr_mask0,
  output reg  [7:0]  io_window_size,
  output reg  [1:0]  boot_mode,
  output reg         boot_wait_host,
  output reg         ser_clk_en
);

  wire [7:0]  straps_sync;
  wire [1:0]  legacy_sync;
  wire        hw_rst_sync;
  reg  [7:0]  strap_reg;
  reg  [1:0]  legacy_reg;
  reg  [7:0]  config_option_reg;
  reg         halt_reg;
  reg  [15:0] ser_cnt_reg;
  wire        soft_reset_bit;
  wire        any_reset;
  wire        io_dec_eff;
  wire        sel_opt;
  wire        sel_straps;
  wire        sel_dec;
  wire        sel_boot;
  reg  [31:0] rd_next;
  reg         in_reset_next;
  reg         halted_next;
  reg         run_en_next;
  reg  [2:0]  nv_type_next;
  reg  [1:0]  nv_kind_next;
  reg         serial_next;
  reg         parallel_next;
  reg         pccard_next;
  reg         strobe_next;
  reg         wide_next;
  reg         map_ram_next;
  reg         rom_off_next;
  reg         legacy_next;
  reg         attr_next;
  reg         io_decode_next;
  reg         mask0_next;
  reg  [7:0]  win_next;
  reg  [1:0]  boot_mode_next;
  reg         wait_host_next;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  rscl_sync3 #(.W(8), .INIT(`RSCL_STRAP_DEFAULT)) u_sync_strap (
    .core_clk (core_clk),
    .rstn     (rstn),
    .pin_in   (strap_data_pins),
    .pin_out  (straps_sync)
  );

  rscl_sync3 #(.W(3), .INIT(8'h04)) u_sync_misc (
    .core_clk (core_clk),
    .rstn     (rstn),
    .pin_in   ({hw_reset_pin, legacy_io_pins}),
    .pin_out  ({hw_rst_sync, legacy_sync})
  );

  // ----------------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------------
  assign soft_reset_bit = config_option_reg[`RSCL_COR_SRST];
  assign any_reset      = hw_rst_sync | soft_reset_bit;

  // ----------------------------------------------------------------------
  // strap sampling and holding
  // ----------------------------------------------------------------------
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      strap_reg  <= `RSCL_STRAP_DEFAULT;
      legacy_reg <= 2'h0;
      halt_reg   <= 1'b0;
    end else if (any_reset) begin
      strap_reg  <= straps_sync;
      legacy_reg <= legacy_sync;
      if (soft_reset_bit) begin
        halt_reg <= 1'b0;
      end else begin
        halt_reg <= straps_sync[`RSCL_SB_HALT];
      end
    end
    // otherwise hold until the next reset
  end

  // ----------------------------------------------------------------------
  // avalon register file
  // ----------------------------------------------------------------------
  assign sel_opt    = (avs_address == `RSCL_OFS_CFG_OPT);
  assign sel_straps = (avs_address == `RSCL_OFS_STRAPS);
  assign sel_dec    = (avs_address == `RSCL_OFS_DECODE);
  assign sel_boot   = (avs_address == `RSCL_OFS_BOOT);

  always @* begin
    rd_next = 32'h0000_0000;
    if (sel_opt) begin
      rd_next = {24'h00_0000, config_option_reg};
    end else if (sel_straps) begin
      rd_next = {22'h00_0000, legacy_reg, strap_reg};
    end else if (sel_dec) begin
      rd_next = {16'h0000, io_window_size, 1'b0, host_addr_mask0,
                 function_regs_io_decode, legacy_bus_select,
                 attr_space_en, pccard_funcs_en, parallel_host_select,
                 serial_host_select};
    end else if (sel_boot) begin
      rd_next = {24'h00_0000, device_in_reset, firmware_run_en,
                 boot_wait_host, boot_mode, nv_device_type};
    end
  end

  // one wait cycle per access: waitrequest drops in the second cycle
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      avs_waitrequest   <= 1'b1;
      avs_readdata      <= 32'h0000_0000;
      config_option_reg <= 8'h00;
    end else begin
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        if (avs_read) begin
          avs_readdata <= rd_next;
        end
      end else begin
        avs_waitrequest <= 1'b1;
      end
      if (avs_write && !avs_waitrequest && sel_opt) begin
        config_option_reg <= avs_writedata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------------
  assign io_dec_eff = ~strap_reg[`RSCL_SB_SERIAL] &
                      (legacy_reg[1] | legacy_reg[0]);

  // ----------------------------------------------------------------------
  // next values of the decoded outputs
  // ----------------------------------------------------------------------
  always @* begin
    in_reset_next  = any_reset;
    halted_next    = halt_reg;
    run_en_next    = ~any_reset & ~halt_reg;
    nv_kind_next   = strap_reg[`RSCL_SB_NV_HI:`RSCL_SB_NV_LO];
    nv_type_next   = {halt_reg,
                      strap_reg[`RSCL_SB_NV_HI:`RSCL_SB_NV_LO]};
    serial_next    = strap_reg[`RSCL_SB_SERIAL];
    parallel_next  = ~strap_reg[`RSCL_SB_SERIAL];
    pccard_next    = ~strap_reg[`RSCL_SB_SERIAL];
    strobe_next    = strap_reg[`RSCL_SB_STROBE];
    wide_next      = strap_reg[`RSCL_SB_WIDE];
    map_ram_next   = strap_reg[`RSCL_SB_MAP_RAM];
    rom_off_next   = strap_reg[`RSCL_SB_ROM_OFF];
    // legacy mode needs the parallel host interface
    legacy_next    = legacy_reg[1] & ~strap_reg[`RSCL_SB_SERIAL];
    // attribute space stays open in serial mode for debug access
    attr_next      = ~legacy_next;
    io_decode_next = io_dec_eff;
    mask0_next     = io_dec_eff;
    win_next       = io_dec_eff ? `RSCL_IO_WIN_LARGE
                                : `RSCL_IO_WIN_SMALL;
    if (strap_reg[`RSCL_SB_NV_HI]) begin
      boot_mode_next = `RSCL_BOOT_NONE;
      wait_host_next = 1'b1;
    end else if (strap_reg[`RSCL_SB_NV_LO]) begin
      boot_mode_next = `RSCL_BOOT_SMALL;
      wait_host_next = 1'b1;
    end else begin
      boot_mode_next = `RSCL_BOOT_LARGE;
      wait_host_next = 1'b0;
    end
  end

  // every decoded output is registered from its next value

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      device_in_reset         <= 1'b1;
      start_halted            <= 1'b0;
      firmware_run_en         <= 1'b0;
      nv_device_type          <= 3'h0;
      nv_kind_select          <= 2'h0;
      serial_host_select      <= 1'b0;
      parallel_host_select    <= 1'b1;
      pccard_funcs_en         <= 1'b1;
      sram_strobe_style       <= 1'b1;
      startup_width_wide      <= 1'b0;
      store_map_to_ram        <= 1'b0;
      onchip_rom_off          <= 1'b1;
      legacy_bus_select       <= 1'b0;
      attr_space_en           <= 1'b1;
      function_regs_io_decode <= 1'b0;
      host_addr_mask0         <= 1'b0;
      io_window_size          <= `RSCL_IO_WIN_SMALL;
      boot_mode               <= `RSCL_BOOT_LARGE;
      boot_wait_host          <= 1'b0;
    end else begin
      device_in_reset         <= in_reset_next;
      start_halted            <= halted_next;
      firmware_run_en         <= run_en_next;
      nv_device_type          <= nv_type_next;
      nv_kind_select          <= nv_kind_next;
      serial_host_select      <= serial_next;
      parallel_host_select    <= parallel_next;
      pccard_funcs_en         <= pccard_next;
      sram_strobe_style       <= strobe_next;
      startup_width_wide      <= wide_next;
      store_map_to_ram        <= map_ram_next;
      onchip_rom_off          <= rom_off_next;
      legacy_bus_select       <= legacy_next;
      attr_space_en           <= attr_next;
      function_regs_io_decode <= io_decode_next;
      host_addr_mask0         <= mask0_next;
      io_window_size          <= win_next;
      boot_mode               <= boot_mode_next;
      boot_wait_host          <= wait_host_next;
    end
  end

  // ----------------------------------------------------------------------
  // boot serial port rate enable
  // ----------------------------------------------------------------------
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ser_cnt_reg <= 16'h0000;
      ser_clk_en  <= 1'b0;
    end else if (ser_cnt_reg == SER_DIV[15:0] - 16'h0001) begin
      ser_cnt_reg <= 16'h0000;
      ser_clk_en  <= 1'b1;
    end else begin
      ser_cnt_reg <= ser_cnt_reg + 16'h0001;
      ser_clk_en  <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* File: tb/rscl_top_chk.sv */
/*
 checker for the strap latch ports.
 assumes binding into rscl_top, one clock, rstn low active.
*/
`timescale 1ns/10ps
`default_nettype none
module rscl_top_chk #(
  parameter SER_DIV = 250
) (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input wire logic        device_in_reset,
  input wire logic        start_halted,
  input wire logic        firmware_run_en,
  input wire logic [1:0]  nv_kind_select,
  input wire logic        serial_host_select,
  input wire logic        parallel_host_select,
  input wire logic        legacy_bus_select,
  input wire logic        function_regs_io_decode,
  input wire logic        host_addr_mask0,
  input wire logic [7:0]  io_window_size,
  input wire logic        ser_clk_en
);
  // ------------------------------------------------------------
  // helpers and properties
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic [15:0] gap_reg;
  logic        seen_reg;
  wire soft_wr = avs_write && !avs_waitrequest && avs_address == 4'h0
                 && avs_writedata[7];
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      gap_reg  <= 16'h0000;
      seen_reg <= 1'b0;
    end else begin
      gap_reg  <= ser_clk_en ? 16'h0000 : gap_reg + 16'h0001;
      seen_reg <= seen_reg | ser_clk_en;
    end
  end
  bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("bus answer late");
  soft_rst_a: assert property (soft_wr |-> ##[1:4] device_in_reset)
    else $error("soft reset not entered");
  halt_clr_a: assert property (soft_wr |-> ##[1:4] !start_halted)
    else $error("halted not cleared");
  halt_run_a: assert property (start_halted |-> !firmware_run_en)
    else $error("firmware runs while halted");
  host_sel_a: assert property (parallel_host_select == !serial_host_select)
    else $error("host select pair wrong");
  legacy_dec_a: assert property (legacy_bus_select |-> parallel_host_select
    && function_regs_io_decode) else $error("legacy decode wrong");
  serial_dec_a: assert property (serial_host_select |->
    !function_regs_io_decode) else $error("io decode not ignored");
  mask_win_a: assert property (host_addr_mask0 == function_regs_io_decode
    && io_window_size == (host_addr_mask0 ? 8'h80 : 8'h40))
    else $error("mask or window wrong");
  ser_div_a: assert property (ser_clk_en && seen_reg |->
    gap_reg == SER_DIV - 1) else $error("serial rate wrong");
  strap_hold_a: assert property (!device_in_reset && !$past(device_in_reset)
    && !$past(device_in_reset, 2) |-> $stable({start_halted, nv_kind_select,
    serial_host_select, legacy_bus_select})) else $error("straps moved");
  cover property (soft_wr);
  cover property (legacy_bus_select);
  cover property (start_halted && !device_in_reset);
endmodule
bind rscl_top rscl_top_chk #(.SER_DIV(SER_DIV)) rscl_top_chk_inst (.*);
`default_nettype wire

/* File: tb/rscl_host_model.sv */
/*
 host side: drives the hardware reset pin and strap levels.
 assumes the bench clock; go starts one reset of HOLD+1 cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module rscl_host_model #(
  parameter HOLD = 1000
) (
  input  wire logic       core_clk,
  input  wire logic       go,
  input  wire logic [7:0] strap_val,
  input  wire logic [1:0] leg_val,
  output var  logic       hw_reset_pin,
  output var  logic [7:0] strap_data_pins,
  output var  logic [1:0] legacy_io_pins,
  output var  logic       busy
);
  // ------------------------------------------------------------
  // reset pulse, then pins reused as data bus
  // ------------------------------------------------------------
  int n;
  initial begin
    hw_reset_pin = 1'h0;
    strap_data_pins = 8'h11;
    legacy_io_pins = 2'h0;
    busy = 1'h0;
    n = 0;
  end
  always @(posedge core_clk) begin
    if (go && !busy) begin
      busy <= 1'h1;
      hw_reset_pin <= 1'h1;
      n <= 0;
      strap_data_pins <= strap_val;
      legacy_io_pins <= leg_val;
    end else if (busy) begin
      n <= n + 1;
      if (n == HOLD)
        hw_reset_pin <= 1'h0;
      if (n == HOLD + 8) begin
        strap_data_pins <= ~strap_val;
        legacy_io_pins <= ~leg_val;
        busy <= 1'h0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/rscl_top_test.sv */
/*
 self-checking bench for the strap latch.
 assumes rscl_top and the host model; avalon master in tasks.
*/
`timescale 1ns/10ps
`default_nettype none
module test_rscl_top;
  logic        core_clk, rstn, go, avs_read, avs_write;
  logic [7:0]  strap_val, s;
  logic [1:0]  leg_val, l;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, rd;
  logic [28:0] e;
  wire  logic  hw_reset_pin, busy, device_in_reset, start_halted;
  wire  logic  firmware_run_en, serial_host_select, parallel_host_select;
  wire  logic  pccard_funcs_en, sram_strobe_style, startup_width_wide;
  wire  logic  store_map_to_ram, onchip_rom_off, legacy_bus_select;
  wire  logic  attr_space_en, function_regs_io_decode, host_addr_mask0;
  wire  logic  boot_wait_host, ser_clk_en, avs_waitrequest;
  wire  logic [1:0]  legacy_io_pins, nv_kind_select, boot_mode;
  wire  logic [2:0]  nv_device_type;
  wire  logic [7:0]  strap_data_pins, io_window_size;
  wire  logic [31:0] avs_readdata;
  int   miscompares, cmp_count, i, n;
  wire [28:0] got_cfg = {start_halted, firmware_run_en, nv_device_type,
    nv_kind_select, serial_host_select, parallel_host_select,
    pccard_funcs_en, sram_strobe_style, startup_width_wide, store_map_to_ram,
    onchip_rom_off, legacy_bus_select, attr_space_en, function_regs_io_decode,
    host_addr_mask0, io_window_size, boot_mode, boot_wait_host};
  rscl_top #(.SER_DIV(4)) rscl_top_inst (.*);
  rscl_host_model rscl_host_model_inst (.*);
  // ------------------------------------------------------------
  // tasks and expectations
  // ------------------------------------------------------------
  function automatic [28:0] exp_cfg(input [7:0] t, input [1:0] g, input h);
    logic p, y, f;
    logic [1:0] b;
    p = !t[5];
    y = g[1] & p;
    f = p & (g[0] | g[1]);
    b = t[7] ? 2'h2 : {1'h0, t[6]};
    exp_cfg = {h, !h, h, t[7:6], t[7:6], t[5], p, p, t[4], t[2], t[1],
      t[0], y, !y, f, f, f ? 8'h80 : 8'h40, b, b != 2'h0};
  endfunction
  task chk(input string nm, input [31:0] x, input [31:0] y);
    cmp_count++;
    if (x !== y) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, y);
    end
  endtask
  task bus(input w, input [3:0] a, input [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'h0) begin
      @(posedge core_clk);
    end
    rd = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge core_clk);
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    // about twice the expected length of the whole run
    #500_000;
    miscompares++;
    results;
  end
  initial begin
    {rstn, go, avs_read, avs_write, strap_val, leg_val} = 0;
    avs_address = 4'h0;
    avs_writedata = 32'h0000_0000;
    n = $urandom(58572);
    repeat (6) @(posedge core_clk);
    rstn <= 1'h1;
    repeat (8) @(posedge core_clk);
    chk("defaults", exp_cfg(8'h11, 2'h0, 1'h0), got_cfg);
    bus(1'h1, 4'h2, 32'h0000_00FF);
    bus(1'h0, 4'h2, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rd);
    bus(1'h1, 4'h0, 32'h0000_005A);
    bus(1'h0, 4'h0, 32'h0000_0000);
    chk("config_option", 32'h0000_005A, rd);
    bus(1'h1, 4'h0, 32'h0000_0000);
    for (i = 0; i < 24; i++) begin
      s = $urandom;
      l = $urandom;
      if (i < 4) begin
        s = {i[1:0], 6'h08};
        l = i[1:0];
      end
      if (i == 23) begin
        s[3] = 1'h1;
      end
      strap_val <= s;
      leg_val <= l;
      go <= 1'h1;
      @(posedge core_clk);
      go <= 1'h0;
      repeat (20) @(posedge core_clk);
      chk("hw_in_reset", 1, device_in_reset);
      while (busy !== 1'h0) begin
        @(posedge core_clk);
      end
      repeat (8) @(posedge core_clk);
      e = exp_cfg(s, l, s[3]);
      chk("cfg", e, got_cfg);
      chk("in_reset", 0, device_in_reset);
      bus(1'h0, 4'h4, 32'h0000_0000);
      chk("straps", {l, s}, rd[9:0]);
      bus(1'h0, 4'h8, 32'h0000_0000);
      chk("decode", {e[10:3], 1'h0, e[11], e[12], e[14], e[13], e[19],
        e[20], e[21]}, rd[15:0]);
      bus(1'h0, 4'hC, 32'h0000_0000);
      chk("boot", {1'h0, e[27], e[0], e[2:1], e[26:24]}, rd[8:0]);
    end
    bus(1'h1, 4'h0, 32'h0000_0080);
    repeat (8) @(posedge core_clk);
    chk("soft_in_reset", 1, device_in_reset);
    chk("soft_halt", 0, start_halted);
    bus(1'h1, 4'h0, 32'h0000_0000);
    repeat (8) @(posedge core_clk);
    chk("soft_cfg", exp_cfg(~s, ~l, 1'h0), got_cfg);
    results;
  end
endmodule
`default_nettype wire
